// >>> verilog/ftsp_poller.sv
// ftsp_poller: host controller running the toggle-bit polling procedure on a flash.
// assumes the flash was just given a program or erase command by other logic.
`timescale 1ns/10ps
`default_nettype none
module ftsp_poller
  import ftsp_pkg::*;
#(
  parameter int unsigned RST_BUSY_CYC = T_RST_BUSY_CYC
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic START,
  input wire logic ABANDON,
  input wire logic ERASE_CHECK,
  input wire logic [ADDR_W-1:0] POLL_ADDR,
  output logic BUSY,
  output logic DONE,
  output ftsp_res_t RESULT,
  output logic ERASE_STARTED,
  output logic [DATA_W-1:0] LAST_STATUS,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic [ADDR_W-1:0] FL_A,
  input wire logic [DATA_W-1:0] FL_DQ_IN,
  output logic [DATA_W-1:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  input wire logic FL_READY_BUSY_PIN
);
  typedef enum logic [3:0] {
    FTSP_IDLE = 4'h0,
    FTSP_RD1 = 4'h1,
    FTSP_RD2 = 4'h2,
    FTSP_RD3 = 4'h3,
    FTSP_WCMD = 4'h4,
    FTSP_WAIT = 4'h5,
    FTSP_FIN = 4'h6
  } ftsp_st_t;

  ftsp_bus_if bus ();
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;
  ftsp_st_t st_r, st_nxt;
  logic [DATA_W-1:0] prev_r, prev_nxt;
  logic [1:0] seq_r, seq_nxt;
  logic abort_r, abort_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;
  logic req_r, req_nxt;
  logic wr_r, wr_nxt;
  logic [ADDR_W-1:0] adr_r, adr_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt;
  ftsp_res_t res_r, res_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;
  logic ers_r, ers_nxt;
  logic [DATA_W-1:0] last_r, last_nxt;
  logic [DATA_W-1:0] flip;

  function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    toggled = a[BIT_TOG] ^ b[BIT_TOG];
  endfunction : toggled

  // pins come from the flash's asynchronous world
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= FL_DQ_IN;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= FL_READY_BUSY_PIN;
      rb_s2_r <= rb_s1_r;
    end
  end

  ftsp_pin_engine u_eng (
    .clk(CLK),
    .srst(SRST),
    .bus(bus.eng),
    .dq_sync(dq_s2_r),
    .ce_n(FL_CE_N),
    .oe_n(FL_OE_N),
    .we_n(FL_WE_N),
    .a_out(FL_A),
    .dq_out(FL_DQ_OUT),
    .dq_oe(FL_DQ_OE)
  );
  assign bus.req = req_r;
  assign bus.wr = wr_r;
  assign bus.addr = adr_r;
  assign bus.wdata = wd_r;
  assign flip = prev_r ^ bus.rdata;

  always_comb begin
    st_nxt = st_r;
    prev_nxt = prev_r;
    seq_nxt = seq_r;
    abort_nxt = abort_r;
    wcnt_nxt = wcnt_r;
    req_nxt = 1'b0;
    wr_nxt = wr_r;
    adr_nxt = adr_r;
    wd_nxt = wd_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    busy_nxt = busy_r;
    ers_nxt = ers_r;
    last_nxt = last_r;
    case (st_r)
      FTSP_IDLE: begin
        if (START) begin
          // polling always opens with a fresh double read
          st_nxt = FTSP_RD1;
          busy_nxt = 1'b1;
          req_nxt = 1'b1;
          wr_nxt = 1'b0;
          adr_nxt = POLL_ADDR;
          res_nxt = FTSP_RES_NONE;
        end
      end
      FTSP_RD1: begin
        if (bus.done) begin
          prev_nxt = bus.rdata;
          st_nxt = FTSP_RD2;
          req_nxt = 1'b1;
        end
      end
      FTSP_RD2: begin
        if (bus.done) begin
          last_nxt = bus.rdata;
          prev_nxt = bus.rdata;
          if (!toggled(prev_r, bus.rdata)) begin
            // toggle stopped: done, suspended, or protected erase ended
            st_nxt = FTSP_FIN;
            res_nxt = (ERASE_CHECK && flip[BIT_SEC]) ? FTSP_RES_SUSPENDED : FTSP_RES_DONE;
          end else begin
            // toggle still moving; the erase bit is trusted only now
            ers_nxt = bus.rdata[BIT_ERS];
            if (bus.rdata[BIT_ABT]) begin
              abort_nxt = 1'b1;
              seq_nxt = 2'd0;
              st_nxt = FTSP_WCMD;
              req_nxt = 1'b1;
              wr_nxt = 1'b1;
              adr_nxt = ADDR_W'(ADR_UNLOCK1);
              wd_nxt = DAT_UNLOCK1;
            end else if (bus.rdata[BIT_TMO]) begin
              st_nxt = FTSP_RD3;
              req_nxt = 1'b1;
            end else if (ABANDON) begin
              st_nxt = FTSP_FIN;
              res_nxt = ERASE_CHECK ? FTSP_RES_ERASING : FTSP_RES_NONE;
            end else begin
              req_nxt = 1'b1;
            end
          end
        end
      end
      FTSP_RD3: begin
        if (bus.done) begin
          last_nxt = bus.rdata;
          if (!toggled(prev_r, bus.rdata)) begin
            st_nxt = FTSP_FIN;
            res_nxt = FTSP_RES_DONE;
          end else begin
            abort_nxt = 1'b0;
            st_nxt = FTSP_WCMD;
            seq_nxt = 2'd2;
            req_nxt = 1'b1;
            wr_nxt = 1'b1;
            adr_nxt = POLL_ADDR;
            wd_nxt = CMD_RESET;
          end
        end
      end
      FTSP_WCMD: begin
        if (bus.done) begin
          if (seq_r == 2'd2) begin
            st_nxt = FTSP_WAIT;
            wcnt_nxt = 16'(RST_BUSY_CYC);
          end else begin
            // abort-reset: two unlock writes then the reset word
            seq_nxt = seq_r + 2'd1;
            req_nxt = 1'b1;
            adr_nxt = (seq_r == 2'd0) ? ADDR_W'(ADR_UNLOCK2) : ADDR_W'(ADR_UNLOCK1);
            wd_nxt = (seq_r == 2'd0) ? DAT_UNLOCK2 : CMD_RESET;
          end
        end
      end
      FTSP_WAIT: begin
        // busy may persist briefly; wait it out or see ready early
        if (wcnt_r == 16'h0000 || rb_s2_r) begin
          st_nxt = FTSP_FIN;
          res_nxt = abort_r ? FTSP_RES_ABORT : FTSP_RES_TIMEOUT;
          ers_nxt = 1'b0;
        end else begin
          wcnt_nxt = wcnt_r - 16'h0001;
        end
      end
      FTSP_FIN: begin
        st_nxt = FTSP_IDLE;
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
      end
      default: st_nxt = FTSP_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_r <= FTSP_IDLE;
      prev_r <= '0;
      seq_r <= 2'd0;
      abort_r <= 1'b0;
      wcnt_r <= 16'h0000;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      adr_r <= '0;
      wd_r <= '0;
      res_r <= FTSP_RES_NONE;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      ers_r <= 1'b0;
      last_r <= '0;
    end else begin
      st_r <= st_nxt;
      prev_r <= prev_nxt;
      seq_r <= seq_nxt;
      abort_r <= abort_nxt;
      wcnt_r <= wcnt_nxt;
      req_r <= req_nxt;
      wr_r <= wr_nxt;
      adr_r <= adr_nxt;
      wd_r <= wd_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      ers_r <= ers_nxt;
      last_r <= last_nxt;
    end
  end

  assign BUSY = busy_r;
  assign DONE = done_r;
  assign RESULT = res_r;
  assign ERASE_STARTED = ers_r;
  assign LAST_STATUS = last_r;
endmodule : ftsp_poller
`default_nettype wire

// >>> verilog/ftsp_pkg.sv
// ftsp_pkg: constants for the host-side toggle-bit status poller.
// assumes a 20 MHz host clock and an asynchronous x16 flash behind plain pins.
package ftsp_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 24;
  // status bit positions on the data bus
  localparam int unsigned BIT_POLL = 7;
  localparam int unsigned BIT_TOG = 6;
  localparam int unsigned BIT_TMO = 5;
  localparam int unsigned BIT_ERS = 3;
  localparam int unsigned BIT_SEC = 2;
  localparam int unsigned BIT_ABT = 1;
  // strobe timing: read low time, then write low time (also the recovery after every strobe), in ns
  localparam int unsigned T_RD_NS = 100;
  localparam int unsigned T_RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_WR_NS = 50;
  localparam int unsigned T_WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
  // busy may linger after reset command, in ns
  localparam int unsigned T_RST_BUSY_NS = 2000;
  localparam int unsigned T_RST_BUSY_CYC = (T_RST_BUSY_NS * CLK_MHZ + 999) / 1000;
  // command words
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [11:0] ADR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADR_UNLOCK2 = 12'h2aa;
  localparam logic [15:0] DAT_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] DAT_UNLOCK2 = 16'h0055;
  // poll outcome codes
  typedef enum logic [2:0] {
    FTSP_RES_NONE = 3'b000,
    FTSP_RES_DONE = 3'b001,
    FTSP_RES_TIMEOUT = 3'b010,
    FTSP_RES_ABORT = 3'b011,
    FTSP_RES_SUSPENDED = 3'b100,
    FTSP_RES_ERASING = 3'b101
  } ftsp_res_t;
endpackage : ftsp_pkg

// >>> verilog/ftsp_bus_if.sv
// ftsp_bus_if: one flash bus cycle request and its completion.
// assumes a single clock shared by the sequencer and the pin engine.
`timescale 1ns/10ps
`default_nettype none
interface ftsp_bus_if;
  import ftsp_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : ftsp_bus_if
`default_nettype wire

// >>> verilog/ftsp_pin_engine.sv
// ftsp_pin_engine: turns one bus request into a timed read or write strobe.
// assumes data input is already two-flop synchronised by the caller.
`timescale 1ns/10ps
`default_nettype none
module ftsp_pin_engine
  import ftsp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  ftsp_bus_if.eng bus,
  input wire logic [DATA_W-1:0] dq_sync,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [ADDR_W-1:0] a_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [1:0] {
    FTSP_E_IDLE = 2'b00,
    FTSP_E_STRB = 2'b01,
    FTSP_E_REC = 2'b10
  } ftsp_est_t;
  ftsp_est_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  logic [ADDR_W-1:0] a_r, a_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rd_nxt = rd_r;
    a_nxt = a_r;
    wd_nxt = wd_r;
    case (st_r)
      FTSP_E_IDLE: begin
        if (bus.req) begin
          st_nxt = FTSP_E_STRB;
          wr_nxt = bus.wr;
          a_nxt = bus.addr;
          wd_nxt = bus.wdata;
          cnt_nxt = bus.wr ? 8'(T_WR_CYC) : 8'(T_RD_CYC + 2);
        end
      end
      FTSP_E_STRB: begin
        if (cnt_r == 8'h00) begin
          // sample after sync latency; strobe release gives the next read its edge
          rd_nxt = dq_sync;
          st_nxt = FTSP_E_REC;
          cnt_nxt = 8'(T_WR_CYC);
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      FTSP_E_REC: begin
        if (cnt_r == 8'h00) begin
          st_nxt = FTSP_E_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: st_nxt = FTSP_E_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= FTSP_E_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= '0;
      a_r <= '0;
      wd_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      rd_r <= rd_nxt;
      a_r <= a_nxt;
      wd_r <= wd_nxt;
    end
  end

  // each read gets its own chip-select frame so the toggle bits advance
  always_ff @(posedge clk) begin
    if (srst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      ce_n <= !(st_nxt == FTSP_E_STRB);
      oe_n <= !(st_nxt == FTSP_E_STRB && !wr_nxt);
      we_n <= !(st_nxt == FTSP_E_STRB && wr_nxt);
      dq_oe <= (st_nxt != FTSP_E_IDLE) && wr_nxt;
    end
  end

  assign a_out = a_r;
  assign dq_out = wd_r;
  assign bus.done = done_r;
  assign bus.rdata = rd_r;
endmodule : ftsp_pin_engine
`default_nettype wire

// >>> verification/ftsp_chk_assertions.sv
// ftsp_chk: timing properties on the poller's top-level ports.
// assumes it is bound onto ftsp_poller with one clock and SRST.
`timescale 1ns/10ps
`default_nettype none
module ftsp_chk
  import ftsp_pkg::*;
#(
  parameter int unsigned RST_BUSY_CYC = 4
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic START,
  input wire logic BUSY,
  input wire logic DONE,
  input wire ftsp_res_t RESULT,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_DQ_OE
);
  logic oe_q_r, oe_q_nxt, we_q_r, we_q_nxt;
  logic [3:0] rd_r, rd_nxt, wr_r, wr_nxt;
  // strobe falls counted per poll, saturating
  always_comb begin
    oe_q_nxt = FL_OE_N;
    we_q_nxt = FL_WE_N;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    if (oe_q_r && !FL_OE_N && rd_r != 4'hf) rd_nxt = rd_r + 4'h1;
    if (we_q_r && !FL_WE_N && wr_r != 4'hf) wr_nxt = wr_r + 4'h1;
    if (START && !BUSY) rd_nxt = 4'h0;
    if (START && !BUSY) wr_nxt = 4'h0;
  end
  always_ff @(posedge CLK) begin
    oe_q_r <= SRST ? 1'b1 : oe_q_nxt;
    we_q_r <= SRST ? 1'b1 : we_q_nxt;
    rd_r <= SRST ? 4'h0 : rd_nxt;
    wr_r <= SRST ? 4'h0 : wr_nxt;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_rd;
    !FL_OE_N && !FL_CE_N && !FL_DQ_OE;
  endsequence
  property p_rst;
    disable iff (1'b0) SRST |=> FL_CE_N && FL_OE_N && FL_WE_N && !FL_DQ_OE && !BUSY && !DONE;
  endproperty
  property p_start;
    START && !BUSY |=> BUSY;
  endproperty
  property p_done_end;
    DONE |=> !DONE && !BUSY;
  endproperty
  property p_two_rd;
    DONE |-> rd_r >= 4'h2;
  endproperty
  property p_tmo;
    DONE && RESULT == FTSP_RES_TIMEOUT |-> rd_r >= 4'h3 && wr_r == 4'h1;
  endproperty
  property p_abt;
    DONE && RESULT == FTSP_RES_ABORT |-> wr_r == 4'h3;
  endproperty
  property p_ok;
    DONE && RESULT inside {FTSP_RES_DONE, FTSP_RES_SUSPENDED, FTSP_RES_ERASING} |-> wr_r == 4'h0;
  endproperty
  property p_wr;
    $fell(FL_WE_N) |-> FL_DQ_OE && !FL_CE_N && FL_OE_N;
  endproperty
  property p_rd_len;
    $fell(FL_OE_N) |-> s_rd [*2];
  endproperty
  a_rst: assert property (p_rst) else $error("strobes not idle after reset");
  a_start: assert property (p_start) else $error("start not taken");
  a_done_end: assert property (p_done_end) else $error("done not a pulse");
  a_two_rd: assert property (p_two_rd) else $error("verdict before two reads");
  a_tmo: assert property (p_tmo) else $error("timeout without recheck or reset");
  a_abt: assert property (p_abt) else $error("abort reset not three writes");
  a_ok: assert property (p_ok) else $error("write during clean poll");
  a_wr: assert property (p_wr) else $error("write cycle without drive");
  a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
endmodule : ftsp_chk
bind ftsp_poller ftsp_chk #(.RST_BUSY_CYC(RST_BUSY_CYC)) u_chk (.CLK(CLK), .SRST(SRST),
  .START(START), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT), .FL_CE_N(FL_CE_N),
  .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_OE(FL_DQ_OE));
`default_nettype wire

// >>> verification/ftsp_flash_model.sv
// ftsp_flash_model: behavioural flash answering status reads and commands.
// assumes the bench arms a mode before each poll; driven by strobes only.
`timescale 1ns/10ps
`default_nettype none
module ftsp_flash_model
  import ftsp_pkg::*;
(
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [DATA_W-1:0] dq_w,
  output logic [DATA_W-1:0] dq_r,
  output logic rdy,
  input wire logic arm,
  input wire logic [2:0] mode,
  input wire logic [7:0] n_tog,
  input wire logic in_sec,
  output logic [3:0] n_rd,
  output logic [3:0] n_wr
);
  logic busy = 1'b0, ers = 1'b0, tog = 1'b0, sec = 1'b0, tmo = 1'b0, abt = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [DATA_W-1:0] last = 16'h0000, word, wd = 16'h0000;
  wire logic rd = !ce_n && !oe_n;
  initial begin
    rdy = 1'b1;
    n_rd = 4'h0;
    n_wr = 4'h0;
  end
  // status overlays every address while busy
  always_comb begin
    if (busy || (ers && in_sec)) word = {8'h00, !busy, tog, tmo, 1'b0, ers, sec, abt, 1'b0};
    else word = {8'h5a, 1'b1, tog, 6'h15};
  end
  // released bus shows inverse of last word, not a stale copy
  assign dq_r = rd ? word : ~last;
  always @(negedge rd) last = word;
  always @(posedge rd) begin
    n_rd = n_rd + 4'h1;
    if (in_sec && ers) sec = ~sec;
    if (busy && cnt == 8'h00) begin
      busy = 1'b0;
      rdy = 1'b1;
    end
    if (busy) tog = ~tog;
    if (busy && cnt != 8'hff) cnt = cnt - 8'h01;
  end
  always @(negedge we_n) #10 wd = dq_w;
  always @(posedge we_n) begin
    n_wr = n_wr + 4'h1;
    if (wd[7:0] == 8'hf0 && (tmo || abt)) begin
      busy = 1'b0;
      tmo = 1'b0;
      abt = 1'b0;
      #1000 rdy = 1'b1;
    end
  end
  always @(posedge arm) begin
    busy = (mode != 3'd3);
    ers = (mode >= 3'd3);
    tmo = (mode == 3'd1);
    abt = (mode == 3'd2);
    rdy = !busy;
    cnt = n_tog;
    n_rd = 4'h0;
    n_wr = 4'h0;
  end
endmodule : ftsp_flash_model
`default_nettype wire

// >>> verification/tb.sv
// tb: self-checking bench for the poller against the flash model.
// assumes the checker is bound onto the poller.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ftsp_pkg::*;
  logic CLK = 1'b0, SRST = 1'b1, START = 1'b0, ABANDON = 1'b0, ERASE_CHECK = 1'b0;
  logic [ADDR_W-1:0] POLL_ADDR = 24'h012340;
  logic BUSY, DONE, ERASE_STARTED, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, rdy;
  ftsp_res_t RESULT;
  logic [DATA_W-1:0] LAST_STATUS, FL_DQ_OUT, m_dq;
  logic [ADDR_W-1:0] FL_A;
  wire logic [DATA_W-1:0] dq_pin = FL_DQ_OE ? FL_DQ_OUT : m_dq;
  logic arm = 1'b0, sec = 1'b0;
  logic [2:0] mode = 3'd0;
  logic [7:0] ntog = 8'h00;
  logic [3:0] n_rd, n_wr;
  // addresses seen at the close of the last write and read strobe, where FL_A is settled
  logic [ADDR_W-1:0] wa = '0, ra = '0;
  always @(posedge FL_WE_N) wa = FL_A;
  always @(posedge FL_OE_N) ra = FL_A;
  int n_errors = 0, n_compared = 0, cyc = 0;
  ftsp_poller #(.RST_BUSY_CYC(T_RST_BUSY_CYC)) dut (.CLK(CLK), .SRST(SRST), .START(START),
    .ABANDON(ABANDON), .ERASE_CHECK(ERASE_CHECK), .POLL_ADDR(POLL_ADDR), .BUSY(BUSY),
    .DONE(DONE), .RESULT(RESULT), .ERASE_STARTED(ERASE_STARTED), .LAST_STATUS(LAST_STATUS),
    .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_A(FL_A),
    .FL_DQ_IN(dq_pin), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_READY_BUSY_PIN(rdy));
  ftsp_flash_model u_fl (.ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .dq_w(dq_pin),
    .dq_r(m_dq), .rdy(rdy), .arm(arm), .mode(mode), .n_tog(ntog), .in_sec(sec),
    .n_rd(n_rd), .n_wr(n_wr));
  initial forever #25 CLK = ~CLK;
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // arms the model, starts a poll, waits for the done pulse
  task automatic poll(input logic [2:0] md, input logic [7:0] nt, input logic s, input logic ab);
    int t = 0;
    @(posedge CLK);
    mode <= md;
    ntog <= nt;
    sec <= s;
    ERASE_CHECK <= s;
    ABANDON <= ab;
    arm <= 1'b1;
    @(posedge CLK);
    arm <= 1'b0;
    START <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    while (DONE !== 1'b1 && t < 400) begin
      @(negedge CLK);
      t++;
    end
    check("done", {15'h0, DONE}, 16'h0001);
  endtask : poll
  task automatic t_done();
    poll(3'd0, 8'd3, 1'b0, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_DONE));
    check("writes", {12'h0, n_wr}, 16'h0000);
    check("rd addr", {15'h0, ra == POLL_ADDR}, 16'h0001);
    $display("test done finished");
  endtask : t_done
  task automatic t_instant();
    poll(3'd0, 8'd0, 1'b0, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_DONE));
    check("reads", {12'h0, n_rd}, 16'h0002);
    $display("test instant finished");
  endtask : t_instant
  task automatic t_timeout();
    poll(3'd1, 8'hff, 1'b0, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_TIMEOUT));
    check("writes", {12'h0, n_wr}, 16'h0001);
    check("wr addr", {15'h0, wa == POLL_ADDR}, 16'h0001);
    // the wait after reset must end on the ready pin, well inside its limit
    check("ready", {15'h0, rdy}, 16'h0001);
    $display("test timeout finished");
  endtask : t_timeout
  task automatic t_recheck();
    poll(3'd1, 8'd2, 1'b0, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_DONE));
    check("reads", {12'h0, n_rd}, 16'h0003);
    $display("test recheck finished");
  endtask : t_recheck
  task automatic t_abort();
    poll(3'd2, 8'hff, 1'b0, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_ABORT));
    check("writes", {12'h0, n_wr}, 16'h0003);
    check("wr addr", {15'h0, wa == ADDR_W'(ADR_UNLOCK1)}, 16'h0001);
    check("ready", {15'h0, rdy}, 16'h0001);
    $display("test abort finished");
  endtask : t_abort
  task automatic t_suspend();
    poll(3'd3, 8'd0, 1'b1, 1'b0);
    check("result", 16'(RESULT), 16'(FTSP_RES_SUSPENDED));
    check("ready", {15'h0, rdy}, 16'h0001);
    $display("test suspend finished");
  endtask : t_suspend
  // outside the erasing sector first, then inside it
  task automatic t_erase();
    poll(3'd4, 8'hff, 1'b0, 1'b1);
    check("result", 16'(RESULT), 16'(FTSP_RES_NONE));
    check("started", {15'h0, ERASE_STARTED}, 16'h0001);
    check("status", LAST_STATUS & 16'h00a8, 16'h0008);
    check("ready", {15'h0, rdy}, 16'h0000);
    poll(3'd4, 8'hff, 1'b1, 1'b1);
    check("result", 16'(RESULT), 16'(FTSP_RES_ERASING));
    check("started", {15'h0, ERASE_STARTED}, 16'h0001);
    $display("test erase finished");
  endtask : t_erase
  // a poll that never settles, cut by reset; the poller must come back idle
  task automatic t_reset();
    @(posedge CLK);
    mode <= 3'd4;
    ntog <= 8'hff;
    sec <= 1'b0;
    ERASE_CHECK <= 1'b0;
    ABANDON <= 1'b0;
    arm <= 1'b1;
    @(posedge CLK);
    arm <= 1'b0;
    START <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    repeat (40) @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    @(negedge CLK);
    check("busy", {15'h0, BUSY}, 16'h0000);
    check("result", 16'(RESULT), 16'(FTSP_RES_NONE));
    check("select", {15'h0, FL_CE_N}, 16'h0001);
    $display("test reset finished");
  endtask : t_reset
  initial begin
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    t_done();
    t_instant();
    t_timeout();
    t_recheck();
    t_abort();
    t_suspend();
    t_erase();
    t_reset();
    t_instant();
    results();
  end
endmodule : tb
`default_nettype wire
